// File: logic/tcpwm_pkg.sv
// Purpose: Shared constants and types of the four-instance timer/counter/PWM unit.
// Assumes: 100 MHz system clock, APB register access with 32-bit data.
// Notes: Channel registers repeat every 32 bytes below the global block.
`default_nettype none
package tcpwm_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NCH = 4;
  localparam int CW = 16;
  localparam int DW = 8;
  localparam int EVW = 3;
  localparam int CTLW = 9;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_CMP = 8'h08;
  localparam logic [7:0] OFF_DEAD = 8'h0C;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_CAPT = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h80;
  localparam logic [7:0] OFF_CLEAR = 8'h84;
  localparam logic [7:0] OFF_IRQEN = 8'h88;
  localparam logic [7:0] OFF_PRESC = 8'h8C;
  // ****************************************
  // Control fields and event bits
  // ****************************************
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_CLK = 3;
  localparam int CTRL_CMP = 5;
  localparam int CTRL_TCALT = 8;
  localparam int CTRL_START = 9;
  localparam int EV_TC = 0;
  localparam int EV_CMP = 1;
  localparam int EV_CAP = 2;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CTLW-1:0] RST_CTRL = 9'h000;
  localparam logic [CW-1:0] RST_PERIOD = 16'hFFFF;
  localparam logic [CW-1:0] RST_CMP = 16'h8000;
  localparam logic [DW-1:0] RST_DEAD = 8'h00;
  localparam logic [DW-1:0] RST_PRESC = 8'h00;
  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [1:0] {mode_free, mode_oneshot, mode_gated} tcpwm_mode_e;
  typedef enum logic [1:0] {clk_sys, clk_presc, clk_ext} tcpwm_clk_e;
  typedef enum logic [2:0] {cmp_less, cmp_less_equal, cmp_equal, cmp_greater_equal, cmp_greater} tcpwm_cmp_e;
endpackage
`default_nettype wire

// File: logic/tcpwm_ch_if.sv
// Purpose: Bundle between the register block and one counting channel.
// Assumes: Every signal is on the system clock.
// Notes: Pulses last one system clock.
`timescale 1ns/10ps
`default_nettype none
interface tcpwm_ch_if;
  import tcpwm_pkg::*;
  logic en;
  tcpwm_mode_e mode;
  tcpwm_cmp_e cmp_sel;
  logic tc_alt;
  logic [CW-1:0] period;
  logic [CW-1:0] cmp_val;
  logic [DW-1:0] dead;
  logic tick;
  logic start;
  logic rst_ev;
  logic cap_ev;
  logic en_lvl;
  logic kill;
  logic [CW-1:0] count;
  logic [CW-1:0] capture;
  logic running;
  logic tc_ev;
  logic tc;
  logic cmp_ev;
  logic out_a;
  logic out_b;
  logic tc_pin;
  modport ctl(output en, mode, cmp_sel, tc_alt, period, cmp_val, dead, tick, start, rst_ev, cap_ev, en_lvl, kill,
    input count, capture, running, tc_ev, tc, cmp_ev, out_a, out_b, tc_pin);
  modport unit(input en, mode, cmp_sel, tc_alt, period, cmp_val, dead, tick, start, rst_ev, cap_ev, en_lvl, kill,
    output count, capture, running, tc_ev, tc, cmp_ev, out_a, out_b, tc_pin);
endinterface
`default_nettype wire

// File: logic/tcpwm_sync.sv
// Purpose: Two-stage synchroniser for pins and fabric inputs.
// Assumes: Inputs may change at any time relative to clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/10ps
`default_nettype none
module tcpwm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: logic/tcpwm_chan.sv
// Purpose: One 16-bit down counter with compare, capture and deadband outputs.
// Assumes: Controls arrive already synchronised and decoded.
// Notes: Outputs are registered except the tc_ev and cmp_ev pulses.
`timescale 1ns/10ps
`default_nettype none
module tcpwm_chan
  import tcpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  tcpwm_ch_if.unit ch
);
  logic adv;
  logic at_zero;
  logic cmp_true;
  logic cmp_q;
  logic stable;
  logic next_a;
  logic next_b;
  logic next_tc;
  logic [DW-1:0] dcnt;

  assign at_zero = ch.count == 16'h0000;
  assign adv = ch.tick & ch.running & ch.en & ((ch.mode != mode_gated) | ch.en_lvl);
  assign ch.tc_ev = adv & at_zero;
  assign ch.cmp_ev = cmp_true & ~cmp_q;
  assign stable = cmp_true == cmp_q;
  // The deadband only opens once the compare level has stood still long enough.
  assign next_a = ~ch.kill & cmp_true & stable & (dcnt >= ch.dead);
  assign next_b = ~ch.kill & ~cmp_true & stable & (dcnt >= ch.dead);
  assign next_tc = adv ? at_zero : ch.tc;

  always_comb begin
    unique case (ch.cmp_sel)
      cmp_less: cmp_true = ch.count < ch.cmp_val;
      cmp_less_equal: cmp_true = ch.count <= ch.cmp_val;
      cmp_equal: cmp_true = ch.count == ch.cmp_val;
      cmp_greater_equal: cmp_true = ch.count >= ch.cmp_val;
      cmp_greater: cmp_true = ch.count > ch.cmp_val;
      default: cmp_true = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch.count <= RST_PERIOD;
      ch.running <= 1'b0;
    end else begin
      if (ch.start | ch.rst_ev) begin
        ch.count <= ch.period;
      end else if (adv) begin
        ch.count <= at_zero ? ch.period : ch.count - 16'h0001;
      end
      if (!ch.en) begin
        ch.running <= 1'b0;
      end else if (ch.start) begin
        ch.running <= 1'b1;
      end else if (ch.tc_ev && ch.mode == mode_oneshot) begin
        ch.running <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch.capture <= 16'h0000;
      cmp_q <= 1'b0;
      dcnt <= 8'h00;
    end else begin
      if (ch.cap_ev) begin
        ch.capture <= ch.count;
      end
      cmp_q <= cmp_true;
      dcnt <= !stable ? 8'h00 : (dcnt == 8'hFF ? dcnt : dcnt + 8'h01);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ch.tc <= 1'b0;
      ch.out_a <= 1'b0;
      ch.out_b <= 1'b0;
      ch.tc_pin <= 1'b0;
    end else begin
      ch.tc <= next_tc;
      ch.out_a <= next_a;
      ch.out_b <= next_b;
      ch.tc_pin <= ch.tc_alt ? next_b : next_tc;
    end
  end
endmodule
`default_nettype wire

// File: logic/tcpwm_top.sv
// Purpose: Four timer/counter/PWM channels behind an APB register slave.
// Assumes: Fabric inputs are asynchronous and are synchronised here.
// Notes: APB answers with no wait state; unmapped accesses report pslverr.
`timescale 1ns/10ps
`default_nettype none
module tcpwm_top
  import tcpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NCH-1:0] cap_in,
  input wire logic [NCH-1:0] en_in,
  input wire logic [NCH-1:0] rst_in,
  input wire logic [NCH-1:0] kill_in,
  input wire logic ext_clk_in,
  output logic [NCH-1:0] cmp_out,
  output logic [NCH-1:0] tc_out,
  output logic irq
);
  // ****************************************
  // Input synchronisers and edges
  // ****************************************
  logic [4*NCH:0] sync_d;
  logic [4*NCH:0] sync_q;
  logic [4*NCH:0] sync_p;
  logic [4*NCH:0] sync_rise;
  logic [NCH-1:0] cap_s;
  logic [NCH-1:0] en_s;
  logic [NCH-1:0] kill_s;
  logic [NCH-1:0] cap_rise;
  logic [NCH-1:0] rst_rise;
  logic ext_rise;

  assign sync_d = {ext_clk_in, kill_in, rst_in, en_in, cap_in};

  // Every pin passes two stages before any edge logic sees it.
  tcpwm_sync #(
    .W(4*NCH+1)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(sync_d),
    .q(sync_q)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_p <= '0;
    end else begin
      sync_p <= sync_q;
    end
  end

  assign sync_rise = sync_q & ~sync_p;
  assign cap_s = sync_q[NCH-1:0];
  assign en_s = sync_q[2*NCH-1:NCH];
  assign kill_s = sync_q[4*NCH-1:3*NCH];
  assign cap_rise = sync_rise[NCH-1:0];
  assign rst_rise = sync_rise[3*NCH-1:2*NCH];
  assign ext_rise = sync_rise[4*NCH];

  // ****************************************
  // APB decode
  // ****************************************
  logic setup;
  logic wr;
  logic is_glob;
  logic aligned;
  logic [1:0] sel_ch;
  logic [7:0] loc;
  logic hit_ctrl;
  logic hit_period;
  logic hit_cmp;
  logic hit_dead;
  logic hit_count;
  logic hit_capt;
  logic hit_status;
  logic hit_clear;
  logic hit_irqen;
  logic hit_presc;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite & mapped;
  assign is_glob = paddr[7];
  assign aligned = paddr[1:0] == 2'h0;
  assign sel_ch = paddr[6:5];
  assign loc = {3'h0, paddr[4:0]};
  assign hit_ctrl = aligned & ~is_glob & (loc == OFF_CTRL);
  assign hit_period = aligned & ~is_glob & (loc == OFF_PERIOD);
  assign hit_cmp = aligned & ~is_glob & (loc == OFF_CMP);
  assign hit_dead = aligned & ~is_glob & (loc == OFF_DEAD);
  assign hit_count = aligned & ~is_glob & (loc == OFF_COUNT);
  assign hit_capt = aligned & ~is_glob & (loc == OFF_CAPT);
  assign hit_status = paddr == OFF_STATUS;
  assign hit_clear = paddr == OFF_CLEAR;
  assign hit_irqen = paddr == OFF_IRQEN;
  assign hit_presc = paddr == OFF_PRESC;
  assign mapped = hit_ctrl | hit_period | hit_cmp | hit_dead | hit_count | hit_capt |
    hit_status | hit_clear | hit_irqen | hit_presc;

  // ****************************************
  // Register storage
  // ****************************************
  logic [CTLW-1:0] ctrl_r [NCH];
  logic [CW-1:0] period_r [NCH];
  logic [CW-1:0] cmp_r [NCH];
  logic [DW-1:0] dead_r [NCH];
  logic [NCH-1:0] start_r;
  logic [NCH*EVW-1:0] status;
  logic [NCH*EVW-1:0] irqen;
  logic [NCH*EVW-1:0] events;
  logic [NCH*EVW-1:0] clr_mask;
  logic [NCH*EVW-1:0] next_status;
  logic [DW-1:0] presc;
  logic [DW-1:0] pcnt;
  logic presc_tick;

  // A start pulse comes from setting the enable bit or writing start with enable.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl_r[i] <= RST_CTRL;
        period_r[i] <= RST_PERIOD;
        cmp_r[i] <= RST_CMP;
        dead_r[i] <= RST_DEAD;
      end
      start_r <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        start_r[i] <= wr & hit_ctrl & (sel_ch == 2'(i)) & pwdata[CTRL_EN] &
          (pwdata[CTRL_START] | ~ctrl_r[i][CTRL_EN]);
        if (wr && sel_ch == 2'(i)) begin
          if (hit_ctrl) ctrl_r[i] <= pwdata[CTLW-1:0];
          if (hit_period) period_r[i] <= pwdata[CW-1:0];
          if (hit_cmp) cmp_r[i] <= pwdata[CW-1:0];
          if (hit_dead) dead_r[i] <= pwdata[DW-1:0];
        end
      end
    end
  end

  // ****************************************
  // Prescaler shared by all channels
  // ****************************************
  assign presc_tick = pcnt == 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc <= RST_PRESC;
      pcnt <= RST_PRESC;
    end else begin
      if (wr && hit_presc) presc <= pwdata[DW-1:0];
      pcnt <= presc_tick ? presc : pcnt - 8'h01;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  tcpwm_ch_if chif [NCH] ();
  logic [CW-1:0] cnt_w [NCH];
  logic [CW-1:0] capt_w [NCH];

  for (genvar gi = 0; gi < NCH; gi++) begin : g_ch
    tcpwm_clk_e csel;
    assign csel = tcpwm_clk_e'(ctrl_r[gi][CTRL_CLK +: 2]);
    assign chif[gi].en = ctrl_r[gi][CTRL_EN];
    assign chif[gi].mode = tcpwm_mode_e'(ctrl_r[gi][CTRL_MODE +: 2]);
    assign chif[gi].cmp_sel = tcpwm_cmp_e'(ctrl_r[gi][CTRL_CMP +: 3]);
    assign chif[gi].tc_alt = ctrl_r[gi][CTRL_TCALT];
    assign chif[gi].period = period_r[gi];
    assign chif[gi].cmp_val = cmp_r[gi];
    assign chif[gi].dead = dead_r[gi];
    assign chif[gi].tick = (csel == clk_sys) | ((csel == clk_presc) & presc_tick) |
      ((csel == clk_ext) & ext_rise);
    assign chif[gi].start = start_r[gi];
    assign chif[gi].rst_ev = rst_rise[gi];
    assign chif[gi].cap_ev = cap_rise[gi];
    assign chif[gi].en_lvl = en_s[gi];
    assign chif[gi].kill = kill_s[gi];
    assign cnt_w[gi] = chif[gi].count;
    assign capt_w[gi] = chif[gi].capture;
    assign events[gi*EVW+EV_TC] = chif[gi].tc_ev;
    assign events[gi*EVW+EV_CMP] = chif[gi].cmp_ev;
    assign events[gi*EVW+EV_CAP] = chif[gi].cap_ev;
    assign cmp_out[gi] = chif[gi].out_a;
    assign tc_out[gi] = chif[gi].tc_pin;
    tcpwm_chan u_chan (
      .clk(clk),
      .rstn(rstn),
      .ch(chif[gi])
    );
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign clr_mask = (wr & hit_clear) ? pwdata[NCH*EVW-1:0] : '0;
  // A new event in the clearing cycle survives the clear.
  assign next_status = (status & ~clr_mask) | events;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      irqen <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wr && hit_irqen) irqen <= pwdata[NCH*EVW-1:0];
      irq <= |(status & irqen);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl) next_rdata[CTLW-1:0] = ctrl_r[sel_ch];
    if (hit_period) next_rdata[CW-1:0] = period_r[sel_ch];
    if (hit_cmp) next_rdata[CW-1:0] = cmp_r[sel_ch];
    if (hit_dead) next_rdata[DW-1:0] = dead_r[sel_ch];
    if (hit_count) next_rdata[CW-1:0] = cnt_w[sel_ch];
    if (hit_capt) next_rdata[CW-1:0] = capt_w[sel_ch];
    if (hit_status) next_rdata[NCH*EVW-1:0] = status;
    if (hit_irqen) next_rdata[NCH*EVW-1:0] = irqen;
    if (hit_presc) next_rdata[DW-1:0] = presc;
  end

  // Data and error are fixed in the setup cycle, so no wait state is needed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= ~mapped;
      end
    end
  end

  // ****************************************
  // Checks on the channels that the scenarios drive
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  down_count_a: assert property (
    chif[0].tc_ev == 1'b0 && g_ch[0].u_chan.adv && !chif[0].start && !chif[0].rst_ev
    |=> chif[0].count == $past(chif[0].count) - 16'h0001)
    else $error("counter did not step down by one");
  gate_hold_a: assert property (
    chif[1].mode == mode_gated && !chif[1].en_lvl && !chif[1].start && !chif[1].rst_ev
    |=> $stable(chif[1].count))
    else $error("gated counter moved without enable");
  reload_a: assert property (
    chif[0].start || chif[0].rst_ev |=> chif[0].count == $past(chif[0].period))
    else $error("period not reloaded");
  reset_reload_a: assert property (
    chif[3].rst_ev |=> chif[3].count == $past(chif[3].period))
    else $error("reload input did not load the period");
  oneshot_stop_a: assert property (
    chif[0].tc_ev && chif[0].mode == mode_oneshot && !chif[0].start |=> !chif[0].running [*2])
    else $error("one shot kept running");
  capture_val_a: assert property (
    chif[2].cap_ev |=> chif[2].capture == $past(chif[2].count))
    else $error("capture value wrong");
  cap_flag_a: assert property (
    chif[2].cap_ev |=> status[2*EVW+EV_CAP])
    else $error("capture event not flagged");
  kill_out_a: assert property (
    chif[1].kill |=> !cmp_out[1] && !chif[1].out_b)
    else $error("kill did not force outputs inactive");
  dead_pair_a: assert property (
    !(chif[1].out_a && chif[1].out_b))
    else $error("complementary outputs active together");
  // A compare flip must first drop both outputs, or an external driver stage could see them overlap.
  dead_gap_a: assert property (
    g_ch[1].u_chan.cmp_true != g_ch[1].u_chan.cmp_q |=> !chif[1].out_a && !chif[1].out_b)
    else $error("outputs switched without a dead gap");
  irq_raise_a: assert property (
    (status & irqen) != '0 |=> irq)
    else $error("enabled status did not raise irq");
  irq_fall_a: assert property (
    (status & irqen) == '0 |=> !irq)
    else $error("irq high with no enabled status");
  clear_bit_a: assert property (
    wr && hit_clear |=> (status & $past(clr_mask) & ~$past(events)) == '0)
    else $error("status bit survived its clear");
  tc_flag_a: assert property (
    chif[0].tc_ev |=> chif[0].tc && status[EV_TC])
    else $error("terminal count not flagged");
  tc_pin_a: assert property (
    !chif[0].tc_alt |=> tc_out[0] == chif[0].tc)
    else $error("terminal count pin does not follow the flag");
  pwm_alt_a: assert property (
    chif[1].tc_alt |=> tc_out[1] == chif[1].out_b)
    else $error("terminal count pin does not carry output b");

  oneshot_end_c: cover property (chif[0].tc_ev && chif[0].mode == mode_oneshot);
  capture_c: cover property (chif[0].cap_ev && chif[0].running);
  kill_c: cover property (chif[1].kill && chif[1].running);
  dead_c: cover property (chif[1].out_b && chif[1].dead != 8'h00);
  irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: tb/tcpwm_fabric_model.sv
// Purpose: Routing fabric and pins that feed the four timer channels.
// Assumes: Requests from the bench change just after a rising clock edge.
// Notes: Pulses are stretched to three clocks and the external clock stands still unless asked to run.
`timescale 1ns/10ps
`default_nettype none
module tcpwm_fabric_model
  import tcpwm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [NCH-1:0] cap_req,
  input wire logic [NCH-1:0] rst_req,
  input wire logic [NCH-1:0] en_lvl,
  input wire logic [NCH-1:0] kill_lvl,
  input wire logic ext_run,
  output logic [NCH-1:0] cap_in,
  output logic [NCH-1:0] rst_in,
  output logic [NCH-1:0] en_in,
  output logic [NCH-1:0] kill_in,
  output logic ext_clk_in
);
  // ****************************************
  // Pin drivers
  // ****************************************
  logic [NCH-1:0] c0, c1, c2, r0, r1, r2;
  logic [1:0] div;
  // A single-clock pulse could fall between synchroniser samples, so every pulse is held three clocks.
  assign cap_in = c0 | c1 | c2;
  assign rst_in = r0 | r1 | r2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {c0, c1, c2, r0, r1, r2, en_in, kill_in} <= '0;
      div <= 2'h0;
      ext_clk_in <= 1'b0;
    end else begin
      {c0, c1, c2} <= {cap_req, c0, c1};
      {r0, r1, r2} <= {rst_req, r0, r1};
      en_in <= en_lvl;
      kill_in <= kill_lvl;
      div <= (ext_run && div != 2'h2) ? div + 2'h1 : 2'h0;
      if (ext_run && div == 2'h2) begin
        ext_clk_in <= !ext_clk_in;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/timer_counter_pwm_unit_tb.sv
// Purpose: Self-checking bench of the four-channel timer unit over APB.
// Assumes: Zero wait state APB slave, fabric inputs through the partner model.
// Notes: Expected counts are worked out from fixed read spacing of forty clocks.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module timer_counter_pwm_unit_tb;
  import tcpwm_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, ext_clk_in, irq, ext_run, e, x;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [NCH-1:0] cap_in, en_in, rst_in, kill_in, cmp_out, tc_out, cap_req, rst_req, en_lvl, kill_lvl;
  logic [15:0] c1, c2, p;
  int err_count, tests_run, m, o, k;
  logic [7:0] offs [5] = '{OFF_CTRL, OFF_PERIOD, OFF_CMP, OFF_DEAD, OFF_COUNT};
  logic [31:0] rv [5] = '{32'h0, 32'h0000FFFF, 32'h00008000, 32'h0, 32'h0000FFFF};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  tcpwm_top i_dut(.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .en_in(en_in),
    .rst_in(rst_in), .kill_in(kill_in), .ext_clk_in(ext_clk_in), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));
  tcpwm_fabric_model i_fab(.clk(clk), .rstn(rstn), .cap_req(cap_req), .rst_req(rst_req), .en_lvl(en_lvl),
    .kill_lvl(kill_lvl), .ext_run(ext_run), .cap_in(cap_in), .rst_in(rst_in), .en_in(en_in), .kill_in(kill_in),
    .ext_clk_in(ext_clk_in));
  // ****************************************
  // Tasks and model
  // ****************************************
  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("unexpected at %0t: no bus answer", $time);
      err_count++;
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Two count reads whose setup cycles lie exactly forty clocks apart.
  task automatic meas(input int ch);
    apb(1'b0, 8'(ch * 32) + OFF_COUNT, 32'h0);
    c1 = rd[15:0];
    cyc(37);
    apb(1'b0, 8'(ch * 32) + OFF_COUNT, 32'h0);
    c2 = c1 - rd[15:0];
  endtask
  task automatic pls(input logic cap, input int ch);
    @(posedge clk);
    if (cap) cap_req[ch] <= 1'b1;
    else rst_req[ch] <= 1'b1;
    @(posedge clk);
    cap_req <= '0;
    rst_req <= '0;
  endtask
  function automatic logic [31:0] ctl(input int en, md, ck, cm, alt);
    return 32'(en + (md << 1) + (ck << 3) + (cm << 5) + (alt << 8));
  endfunction
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic cmp_m(input int md, c, v);
    case (md)
      0: return c < v;
      1: return c <= v;
      2: return c == v;
      3: return c >= v;
      default: return c > v;
    endcase
  endfunction
  initial begin
    repeat (60000) @(posedge clk);
    $display("unexpected at %0t: run too long", $time);
    err_count++;
    print_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rs = 88; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; cap_req = 0; rst_req = 0;
    en_lvl = 0; kill_lvl = 0; ext_run = 0; err_count = 0; tests_run = 0;
    cyc(20);
    rstn <= 1'b1;
    for (m = 0; m < NCH; m++) begin
      for (k = 0; k < 5; k++) begin
        apb(1'b0, 8'(m * 32) + offs[k], 32'h0);
        `CHK(rd, rv[k])
      end
    end
    apb(1'b0, OFF_STATUS, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 8'h90, 32'h0); `CHK({e, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, 32'h0); `CHK(e, 1'b1)
    apb(1'b1, OFF_COUNT, 32'h00001234);
    apb(1'b0, OFF_COUNT, 32'h0); `CHK(rd, 32'h0000FFFF)
    // Clock sources: system, prescaler of four, external.
    apb(1'b1, OFF_PERIOD, 32'd60000);
    apb(1'b1, OFF_PRESC, 32'h3);
    for (m = 0; m < 3; m++) begin
      apb(1'b1, OFF_CTRL, 32'h0);
      apb(1'b1, OFF_CTRL, ctl(1, 0, m, 7, 0));
      ext_run <= (m == 2);
      cyc(5);
      meas(0);
      if (m == 0) `CHK(c2, 16'd40)
      else if (m == 1) `CHK(c2, 16'd10)
      else `CHK(c2 >= 6 && c2 <= 7, 1'b1)
    end
    ext_run <= 1'b0;
    cyc(5);
    meas(0); `CHK(c2, 16'd0)
    // One shot with the interrupt masked, then enabled, then cleared.
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_PERIOD, 32'd5);
    apb(1'b1, OFF_CLEAR, 32'h00000FFF);
    apb(1'b1, OFF_CTRL, ctl(1, 1, 0, 7, 0));
    cyc(30);
    meas(0); `CHK(c2, 16'd0)
    apb(1'b0, OFF_STATUS, 32'h0); `CHK(rd[EV_TC], 1'b1)
    `CHK(irq, 1'b0)
    apb(1'b1, OFF_IRQEN, 32'h1); cyc(3); `CHK(irq, 1'b1)
    apb(1'b1, OFF_CLEAR, 32'h1); cyc(3); `CHK(irq, 1'b0)
    apb(1'b0, OFF_STATUS, 32'h0); `CHK(rd[EV_TC], 1'b0)
    // Compare table on channel 1, held in gated mode with enable low.
    p = 16'h0100 + 16'(xs() % 32'h0000FE00);
    apb(1'b1, 8'h20 + OFF_PERIOD, 32'(p));
    for (m = 0; m < 5; m++) begin
      for (o = -1; o < 2; o++) begin
        apb(1'b1, 8'h20 + OFF_CMP, 32'(int'(p) + o));
        apb(1'b1, 8'h20 + OFF_CTRL, ctl(1, 2, 0, m, 1));
        cyc(6);
        x = cmp_m(m, int'(p), int'(p) + o);
        `CHK({cmp_out[1], tc_out[1]}, {x, !x})
      end
    end
    apb(1'b0, OFF_STATUS, 32'h0); `CHK(rd[EVW + EV_CMP], 1'b1)
    meas(1); `CHK(c2, 16'd0)
    en_lvl[1] <= 1'b1; cyc(5);
    meas(1); `CHK(c2, 16'd40)
    en_lvl[1] <= 1'b0;
    apb(1'b1, 8'h20 + OFF_CTRL, ctl(1, 2, 0, 3, 1));
    apb(1'b1, 8'h20 + OFF_CMP, 32'h0);
    kill_lvl[1] <= 1'b1; cyc(6);
    `CHK({cmp_out[1], tc_out[1]}, 2'b00)
    kill_lvl[1] <= 1'b0; cyc(6);
    `CHK({cmp_out[1], tc_out[1]}, 2'b10)
    apb(1'b1, 8'h20 + OFF_DEAD, 32'd20);
    apb(1'b1, 8'h20 + OFF_CTRL, ctl(1, 2, 0, 7, 1));
    cyc(8); `CHK({cmp_out[1], tc_out[1]}, 2'b00)
    cyc(25); `CHK({cmp_out[1], tc_out[1]}, 2'b01)
    // Capture on channel 2 lands a few clocks after the read count.
    apb(1'b1, OFF_CLEAR, 32'h00000FFF);
    apb(1'b1, 8'h40 + OFF_PERIOD, 32'd60000);
    apb(1'b1, 8'h40 + OFF_CTRL, ctl(1, 0, 0, 7, 0));
    cyc(5);
    apb(1'b0, 8'h40 + OFF_COUNT, 32'h0);
    c1 = rd[15:0];
    pls(1'b1, 2); cyc(10);
    apb(1'b0, 8'h40 + OFF_CAPT, 32'h0);
    c2 = c1 - rd[15:0];
    `CHK(c2 > 0 && c2 < 16, 1'b1)
    apb(1'b0, OFF_STATUS, 32'h0); `CHK(rd[3 * 2 + EV_CAP], 1'b1)
    // Reload input on channel 3 brings the count back near its period.
    apb(1'b1, 8'h60 + OFF_PERIOD, 32'd1000);
    apb(1'b1, 8'h60 + OFF_CTRL, ctl(1, 0, 0, 7, 0));
    cyc(300);
    pls(1'b0, 3); cyc(10);
    apb(1'b0, 8'h60 + OFF_COUNT, 32'h0);
    `CHK(rd[15:0] <= 1000 && rd[15:0] > 985, 1'b1)
    print_verdict();
  end
endmodule
`default_nettype wire
